// >>> rtl/arf_defs.vh
// Register map, field positions, reset values and timing counts for the converter control
`ifndef ARF_DEFS_VH
`define ARF_DEFS_VH
// ====================================================================
// Register byte addresses (one aligned word each)
`define ARF_OFF_CHANNEL_GO      12'h000
`define ARF_OFF_TRIGGER_REF     12'h004
`define ARF_OFF_FORMAT_TIMING   12'h008
`define ARF_OFF_RESULT_HIGH     12'h00C
`define ARF_OFF_RESULT_LOW      12'h010
`define ARF_OFF_SAMPLE_IN       12'h014
// ====================================================================
// Field positions
`define ARF_GO_BIT              1
`define ARF_ENABLE_BIT          0
`define ARF_CHAN_LSB            2
`define ARF_FMT_BIT             7
`define ARF_ACQT_LSB            3
`define ARF_CS_LSB              0
// ====================================================================
// Writable masks and reset values
`define ARF_MASK_CHANNEL_GO     8'h7F
`define ARF_MASK_TRIGGER_REF    8'h8F
`define ARF_MASK_FORMAT_TIMING  8'hBF
`define ARF_RST_CTRL            8'h00
`define ARF_RST_RESULT          8'h00
// ====================================================================
// Timing: dedicated conversion clock, 600 kHz nominal, at 200 MHz core rate
`define ARF_CORE_HZ             200000000
`define ARF_FRC_HZ              600000
`define ARF_FRC_DIV             (`ARF_CORE_HZ / `ARF_FRC_HZ)
`define ARF_CONV_TADS           11
`define ARF_RESULT_BITS         10
`define ARF_AXI_OKAY            2'b00
`define ARF_AXI_SLVERR          2'b10
`endif

// >>> rtl/arf_tad_gen.v
// Conversion clock period enable generator
`timescale 1ns/1ps
`include "arf_defs.vh"
module arf_tad_gen #(
	parameter FRC_DIV = `ARF_FRC_DIV
) (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst_n,
	// Control
	input  wire       run,
	input  wire [2:0] clk_sel,
	// Enable out
	output reg        tad_en
);
	reg [15:0] cnt_r;
	reg [15:0] limit;

	// ====================================================================
	// Divider select
	always @* begin
		case (clk_sel)
			3'h0:    limit = 16'h0001;
			3'h1:    limit = 16'h0007;
			3'h2:    limit = 16'h001F;
			3'h4:    limit = 16'h0003;
			3'h5:    limit = 16'h000F;
			3'h6:    limit = 16'h003F;
			default: limit = FRC_DIV[15:0] - 16'h0001;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= 16'h0000;
			tad_en <= 1'b0;
		end else if (!run) begin
			cnt_r  <= 16'h0000;
			tad_en <= 1'b0;
		end else if (cnt_r >= limit) begin
			cnt_r  <= 16'h0000;
			tad_en <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 16'h0001;
			tad_en <= 1'b0;
		end
	end
endmodule // arf_tad_gen

// >>> rtl/arf_sar_core.v
// Successive-approximation engine: acquisition, ten bit decisions, hold discharge
`timescale 1ns/1ps
module arf_sar_core (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst_n,
	// Control
	input  wire       start,
	input  wire       abort,
	input  wire       tad_en,
	input  wire [2:0] acq_sel,
	input  wire [9:0] sample,
	// Status and result
	output reg        busy,
	output reg        done,
	output reg  [9:0] result,
	output reg        hold_charged
);
`include "arf_defs.vh"
	localparam S_IDLE = 3'b001;
	localparam S_ACQ  = 3'b010;
	localparam S_CONV = 3'b100;
	reg [2:0] state_r;
	reg [4:0] cnt_r;
	reg [9:0] trial_r;
	reg [9:0] held_r;
	reg [4:0] acq_tads;

	// Acquisition length in conversion periods
	function [4:0] acq_len;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    acq_len = 5'd0;
				3'h1:    acq_len = 5'd2;
				3'h2:    acq_len = 5'd4;
				3'h3:    acq_len = 5'd6;
				3'h4:    acq_len = 5'd8;
				3'h5:    acq_len = 5'd12;
				3'h6:    acq_len = 5'd16;
				default: acq_len = 5'd20;
			endcase
		end
	endfunction

	always @* acq_tads = acq_len(acq_sel);

	// ====================================================================
	// Sequencer
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= S_IDLE;
			cnt_r        <= 5'd0;
			trial_r      <= 10'h000;
			held_r       <= 10'h000;
			busy         <= 1'b0;
			done         <= 1'b0;
			result       <= 10'h000;
			hold_charged <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (start) begin
						busy         <= 1'b1;
						hold_charged <= 1'b1;
						cnt_r        <= 5'd0;
						state_r      <= S_ACQ;
					end
				end
				S_ACQ: begin
					if (abort) begin
						busy <= 1'b0; hold_charged <= 1'b0; state_r <= S_IDLE;
					end else if (cnt_r >= acq_tads) begin
						held_r  <= sample;
						trial_r <= 10'h200;
						cnt_r   <= 5'd0;
						state_r <= S_CONV;
					end else if (tad_en) begin
						cnt_r <= cnt_r + 5'd1;
					end
				end
				S_CONV: begin
					if (abort) begin
						busy <= 1'b0; hold_charged <= 1'b0; state_r <= S_IDLE;
					end else if (tad_en) begin
						if (cnt_r == `ARF_RESULT_BITS) begin
							result       <= trial_r;  // [R5]
							done         <= 1'b1;
							busy         <= 1'b0;
							hold_charged <= 1'b0;     // [R4]
							state_r      <= S_IDLE;
						end else begin
							// One decision per period, MSB first
							if (held_r < trial_r)
								trial_r <= (trial_r & ~(10'h200 >> cnt_r)) |
									((10'h200 >> cnt_r) >> 1);
							else
								trial_r <= trial_r | ((10'h200 >> cnt_r) >> 1);
							cnt_r <= cnt_r + 5'd1;
						end
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // arf_sar_core

// >>> rtl/arf_adc_top.v
// Converter control top: AXI4-Lite registers, result formatting, conversion sequencing
//
// Behaviour
// R1: Right format: result 9:8 in high bits 1:0
// R2: Right format: result 7:0 in low byte
// R3: Software waits acquisition after channel change
// R4: Hold element discharged after every conversion
// R5: Result has 1024 steps, ten bits
// R6: Go bit starts conversion, self-clears
// R7: Format select bit 7: 1 right, 0 left
// R8: Left format: 9:2 high, 1:0 low 7:6
// R9: Both result bytes updated before go clears; the code loads them on the same edge that clears go, and not at all on abort
`timescale 1ns/1ps
`include "arf_defs.vh"
module arf_adc_top #(
	parameter FRC_DIV = `ARF_FRC_DIV
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Analog front end
	input  wire [9:0]  analog_sample,
	output reg  [4:0]  channel_sel,
	output reg         sample_hold_capacitor
);
	// ====================================================================
	// Registers
	reg  [7:0]  chan_go_r;
	reg  [7:0]  trig_ref_r;
	reg  [7:0]  fmt_tim_r;
	reg  [7:0]  res_hi_r;
	reg  [7:0]  res_lo_r;
	reg  [11:0] aw_addr_r;
	reg  [31:0] w_data_r;
	reg         aw_have_r;
	reg         w_have_r;
	reg         w_strb0_r;
	reg  [9:0]  samp_s1_r;
	reg  [9:0]  samp_s2_r;
	reg  [9:0]  samp_s3_r;
	reg  [9:0]  samp_stable_r;
	wire        busy;
	wire        done;
	wire        hold;
	wire        tad_en;
	wire [9:0]  conversion_result_word;
	wire        wr_fire;
	wire        go_set;
	wire        enable;
	wire        wr_hit;
	reg  [7:0]  chan_go_nxt;
	reg  [7:0]  trig_ref_nxt;
	reg  [7:0]  fmt_tim_nxt;
	reg  [7:0]  res_hi_nxt;
	reg  [7:0]  res_lo_nxt;
	reg  [4:0]  chan_sel_nxt;

	localparam [7:0] GO_MASK = 8'h01 << `ARF_GO_BIT;

	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_hit  = wr_fire && w_strb0_r;
	assign enable  = chan_go_r[`ARF_ENABLE_BIT];
	// A start is refused while a conversion runs or the converter stays off
	assign go_set  = wr_fire && w_strb0_r && aw_addr_r == `ARF_OFF_CHANNEL_GO &&
		w_data_r[`ARF_GO_BIT] && enable_nxt(w_data_r[7:0]) && !busy;  // [R6]

	function enable_nxt;
		input [7:0] d;
		begin
			enable_nxt = d[`ARF_ENABLE_BIT];
		end
	endfunction

	// Whether a word address names a register; the sample word is read only
	function addr_known;
		input [11:0] a;
		input        for_read;
		begin
			addr_known = (a <= `ARF_OFF_RESULT_LOW) ||
				(for_read && a == `ARF_OFF_SAMPLE_IN);
		end
	endfunction

	// ====================================================================
	// Sample input synchroniser: accepted when stages two and three agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_s1_r     <= 10'h000;
			samp_s2_r     <= 10'h000;
			samp_s3_r     <= 10'h000;
			samp_stable_r <= 10'h000;
		end else begin
			samp_s1_r <= analog_sample;
			samp_s2_r <= samp_s1_r;
			samp_s3_r <= samp_s2_r;
			if (samp_s2_r == samp_s3_r)
				samp_stable_r <= samp_s3_r;
		end
	end

	// ====================================================================
	// Conversion engine
	arf_tad_gen #(
		.FRC_DIV (FRC_DIV)
	) u_tad (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (busy),
		.clk_sel  (fmt_tim_r[`ARF_CS_LSB +: 3]),
		.tad_en   (tad_en)
	);

	arf_sar_core u_sar (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.start        (go_set),
		.abort        (!enable),
		.tad_en       (tad_en),
		.acq_sel      (fmt_tim_r[`ARF_ACQT_LSB +: 3]),
		.sample       (samp_stable_r),
		.busy         (busy),
		.done         (done),
		.result       (conversion_result_word),
		.hold_charged (hold)
	);

	// ====================================================================
	// AXI4-Lite write path: address and data taken in either order
	// Each ready is a one-cycle pulse, so the master holds valid until it
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ARF_AXI_OKAY;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 12'h000;
			w_data_r      <= 32'h0000_0000;
			w_strb0_r     <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r  <= 1'b1;
				w_data_r  <= s_axi_wdata;
				w_strb0_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_known(aw_addr_r, 1'b0) ?
					`ARF_AXI_OKAY : `ARF_AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ====================================================================
	// Register file next values: conversion end wins over a same-cycle write
	// to a result byte, and a start wins over the automatic go clear
	always @* begin
		chan_go_nxt  = chan_go_r;
		trig_ref_nxt = trig_ref_r;
		fmt_tim_nxt  = fmt_tim_r;
		res_hi_nxt   = res_hi_r;
		res_lo_nxt   = res_lo_r;
		chan_sel_nxt = channel_sel;
		if (wr_hit) begin
			case (aw_addr_r)
				`ARF_OFF_CHANNEL_GO: begin
					// Go is never cleared by software, only by the sequencer
					chan_go_nxt  = (w_data_r[7:0] & `ARF_MASK_CHANNEL_GO & ~GO_MASK) |
						(chan_go_r & GO_MASK);
					chan_sel_nxt = w_data_r[`ARF_CHAN_LSB +: 5];  // [R3]
				end
				`ARF_OFF_TRIGGER_REF:
					trig_ref_nxt = w_data_r[7:0] & `ARF_MASK_TRIGGER_REF;
				`ARF_OFF_FORMAT_TIMING:
					fmt_tim_nxt = w_data_r[7:0] & `ARF_MASK_FORMAT_TIMING;
				`ARF_OFF_RESULT_HIGH:
					res_hi_nxt = w_data_r[7:0];
				`ARF_OFF_RESULT_LOW:
					res_lo_nxt = w_data_r[7:0];
				default: ;
			endcase
		end
		if (done) begin
			// Both bytes in the same edge that clears go
			if (fmt_tim_r[`ARF_FMT_BIT]) begin  // [R7]
				res_hi_nxt = {6'b000000, conversion_result_word[9:8]};  // [R1] [R9]
				res_lo_nxt = conversion_result_word[7:0];  // [R2] [R9]
			end else begin
				res_hi_nxt = conversion_result_word[9:2];  // [R8] [R9]
				res_lo_nxt = {conversion_result_word[1:0], 6'b000000};  // [R8]
			end
		end
		// A start in the same cycle as a finish keeps go set
		if (go_set)
			chan_go_nxt = chan_go_nxt | GO_MASK;  // [R6]
		else if (done || !busy)
			chan_go_nxt = chan_go_nxt & ~GO_MASK;  // [R6]
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_go_r             <= `ARF_RST_CTRL;
			trig_ref_r            <= `ARF_RST_CTRL;
			fmt_tim_r             <= `ARF_RST_CTRL;
			res_hi_r              <= `ARF_RST_RESULT;
			res_lo_r              <= `ARF_RST_RESULT;
			channel_sel           <= 5'h00;
			sample_hold_capacitor <= 1'b0;
		end else begin
			sample_hold_capacitor <= hold;  // [R4]
			chan_go_r             <= chan_go_nxt;
			trig_ref_r            <= trig_ref_nxt;
			fmt_tim_r             <= fmt_tim_nxt;
			res_hi_r              <= res_hi_nxt;
			res_lo_r              <= res_lo_nxt;
			channel_sel           <= chan_sel_nxt;
		end
	end

	// ====================================================================
	// AXI4-Lite read path
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ARF_AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= addr_known({s_axi_araddr[11:2], 2'b00}, 1'b1) ?
					`ARF_AXI_OKAY : `ARF_AXI_SLVERR;
				case ({s_axi_araddr[11:2], 2'b00})
					`ARF_OFF_CHANNEL_GO:    s_axi_rdata <= {24'h00_0000, chan_go_r};
					`ARF_OFF_TRIGGER_REF:   s_axi_rdata <= {24'h00_0000, trig_ref_r};
					`ARF_OFF_FORMAT_TIMING: s_axi_rdata <= {24'h00_0000, fmt_tim_r};
					`ARF_OFF_RESULT_HIGH:   s_axi_rdata <= {24'h00_0000, res_hi_r};
					`ARF_OFF_RESULT_LOW:    s_axi_rdata <= {24'h00_0000, res_lo_r};
					`ARF_OFF_SAMPLE_IN:     s_axi_rdata <= {22'h00_0000, samp_stable_r};
					default:                s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // arf_adc_top

// >>> verif/arf_adc_checker.sv
// Port checker for the converter control top
`timescale 1ns/1ps
`include "arf_defs.vh"
module arf_adc_checker #(
	parameter FRC_DIV = `ARF_FRC_DIV
) (
	// Clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// Register bus
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// Analog side
	input wire        sample_hold_capacitor
);
	localparam int TMAX = (FRC_DIV > 64) ? FRC_DIV : 64;
	localparam int HMAX = 32 * TMAX;
	logic [15:0] hold_cnt_r;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ======
	// Length of the current hold-connected stretch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			hold_cnt_r <= 16'h0000;
		else if (sample_hold_capacitor)
			hold_cnt_r <= hold_cnt_r + 16'h0001;
		else
			hold_cnt_r <= 16'h0000;
	end
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence ar_unmapped;
		{s_axi_araddr[11:2], 2'b00} > `ARF_OFF_SAMPLE_IN;
	endsequence
	// ======
	// Properties
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_R_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_UNMAPPED: assert property (ar_taken ##0 ar_unmapped |=> s_axi_rresp == `ARF_AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wready, 2) || $past(s_axi_awready, 2))
		else $error("write response without data");
	AST_HOLD_BOUND: assert property (hold_cnt_r <= HMAX)
		else $error("hold element never discharged");
endmodule // arf_adc_checker

bind arf_adc_top arf_adc_checker #(.FRC_DIV(FRC_DIV)) u_chk (.*);

// >>> verif/testbench.sv
// Self-checking bench for the converter control top
`timescale 1ns/1ps
`include "arf_defs.vh"
module testbench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [9:0]  sample = 10'h000;
	logic [3:0]  wstrb = 4'hF;
	wire         awready, wready, bvalid, arready, rvalid, hold;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [4:0]  chan;
	int          fails = 0;
	int          checks_done = 0;
	int          n = 0;
	arf_adc_top #(.FRC_DIV(4)) dut (
		.core_clk(core_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.analog_sample(sample), .channel_sel(chan), .sample_hold_capacitor(hold)
	);
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	// ======
	// Expected result bytes
	function automatic logic [7:0] exp_hi(input logic [9:0] v, input logic f);
		return f ? {6'h00, v[9:8]} : v[9:2];
	endfunction
	function automatic logic [7:0] exp_lo(input logic [9:0] v, input logic f);
		return f ? v[7:0] : {v[1:0], 6'h00};
	endfunction
	// ======
	// Checking, closing and bus tasks
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick;
		@(posedge core_clk);
		n++;
		if (n > 5000) begin
			fails++;
			$display("MISMATCH %0t bus wait ran out", $time);
			conclude();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		n = 0;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'($urandom);
		forever begin
			tick();
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
			if (bvalid)
				bready <= 1'b1;
		end
		check(bresp, er);
		bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'($urandom);
		forever begin
			tick();
			if (arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
			if (rvalid)
				rready <= 1'b1;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check({r, d}, {er, 24'h00_0000, e});
	endtask
	// ======
	// Main sequence
	initial begin : main
		logic [31:0] d;
		logic [1:0]  r;
		logic [9:0]  v;
		logic [4:0]  ch;
		logic        f;
		void'($urandom(32'h3cbf_7a23));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int a = 0; a < 5; a++)
			rdc(12'(a * 4), `ARF_RST_CTRL, `ARF_AXI_OKAY);
		wr(12'h004, 8'hFF, `ARF_AXI_OKAY);
		rdc(12'h004, `ARF_MASK_TRIGGER_REF, `ARF_AXI_OKAY);
		wr(12'h010, 8'hA5, `ARF_AXI_OKAY);
		rdc(12'h010, 8'hA5, `ARF_AXI_OKAY);
		wstrb <= 4'h0;
		wr(12'h010, 8'h5A, `ARF_AXI_OKAY);
		wstrb <= 4'hF;
		rdc(12'h010, 8'hA5, `ARF_AXI_OKAY);
		wr(12'h020, 8'h11, `ARF_AXI_SLVERR);
		rdc(12'h018, 8'h00, `ARF_AXI_SLVERR);
		wr(12'h000, 8'h06, `ARF_AXI_OKAY);
		rdc(12'h000, 8'h04, `ARF_AXI_OKAY);
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
			ch = 5'($urandom);
			f = i[0];
			sample <= v;
			wr(12'h008, {f, 1'b0, 3'(7 - i), 3'(i)}, `ARF_AXI_OKAY);
			wr(12'h000, {1'b0, ch, 2'b01}, `ARF_AXI_OKAY);
			check(chan, ch);
			repeat (8) @(posedge core_clk);
			wr(12'h000, {1'b0, ch, 2'b11}, `ARF_AXI_OKAY);
			check(hold, 1'b1);
			rdc(12'h000, {1'b0, ch, 2'b11}, `ARF_AXI_OKAY);
			d = 32'h0000_0002;
			for (int k = 0; k < 1000 && d[1]; k++)
				rd(12'h000, d, r);
			check(d[1], 1'b0);
			check(hold, 1'b0);
			rdc(12'h00C, exp_hi(v, f), `ARF_AXI_OKAY);
			rdc(12'h010, exp_lo(v, f), `ARF_AXI_OKAY);
		end
		$display("conversion test done");
		wr(12'h008, 8'h3A, `ARF_AXI_OKAY);
		sample <= ~v;
		wr(12'h000, 8'h03, `ARF_AXI_OKAY);
		wr(12'h000, 8'h00, `ARF_AXI_OKAY);
		rdc(12'h000, 8'h00, `ARF_AXI_OKAY);
		check(hold, 1'b0);
		rdc(12'h00C, exp_hi(v, f), `ARF_AXI_OKAY);
		$display("abort test done");
		conclude();
	end
endmodule // testbench
